// ==== core/dcc_change_det.sv ====
/*
  Change detector: synchronises both raw comparator decisions, gates
  them with the power state and compares them with a captured copy.
  Assumes the raw decisions are asynchronous to sys_clk_in.
*/
`timescale 1ns/1ps
`default_nettype none

module dcc_change_det (
  input wire logic sys_clk_in, // system clock
  input wire logic nrst_in, // synchronous reset, active low
  input wire dcc_pkg::dcc_cmp_pair_t raw_in, // raw comparator decisions
  input wire logic powered_in, // comparators active
  input wire logic capture_in, // take present state as reference
  output dcc_pkg::dcc_cmp_pair_t status_out, // synchronised, gated state
  output logic mismatch_out // state differs from reference
);
  import dcc_pkg::*;

  dcc_cmp_pair_t meta_ff;
  dcc_cmp_pair_t sync_ff;
  dcc_cmp_pair_t ref_ff;
  dcc_cmp_pair_t gated;

  // ----------------------------------------------------------------------
  // two-stage synchroniser
  // ----------------------------------------------------------------------
  // synchronise before compare
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= raw_in;
      sync_ff <= meta_ff;
    end
  end

  // unpowered comparators read as low
  assign gated = powered_in ? sync_ff : '0;
  assign status_out = gated;

  // ----------------------------------------------------------------------
  // reference state
  // ----------------------------------------------------------------------
  // access captures new reference
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      ref_ff <= '0;
    end else if (capture_in) begin
      ref_ff <= gated;
    end
  end

  // either output changing is a mismatch
  assign mismatch_out = (gated != ref_ff);

endmodule

`default_nettype wire

// ==== core/dcc_consts.svh ====
/*
  Constants of the dual comparator control block: register indices,
  field positions, reset values and the mode codes.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define DCC_IDX_PORT_DATA 8'h05
`define DCC_IDX_INT_CTRL 8'h0b
`define DCC_IDX_PERIPH_FLAGS 8'h0c
`define DCC_IDX_CMP_CTRL 8'h1f
`define DCC_IDX_PORT_DIR 8'h85
`define DCC_IDX_PERIPH_EN 8'h8c
`define DCC_IDX_VREF_CTRL 8'h9f

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DCC_BIT_GLOBAL_IRQ_EN 7
`define DCC_BIT_PERIPH_IRQ_EN 6
`define DCC_BIT_PAR_PORT 7
`define DCC_BIT_CMP_IRQ 6
`define DCC_BIT_SECOND_OUT 7
`define DCC_BIT_FIRST_OUT 6
`define DCC_BIT_INPUT_SWITCH 3
`define DCC_MODE_MSB 2
`define DCC_MODE_LSB 0
`define DCC_BIT_PIN_THREE 3
`define DCC_BIT_PIN_FOUR 4

// ----------------------------------------------------------------------
// reset values and read masks
// ----------------------------------------------------------------------
`define DCC_RST_INT_CTRL 8'h00
`define DCC_RST_PERIPH_FLAGS 8'h00
`define DCC_RST_CMP_CTRL 4'h0
`define DCC_RST_PORT_DIR 6'h3f
`define DCC_RST_PERIPH_EN 8'h00
`define DCC_RST_VREF_CTRL 8'h00
`define DCC_RST_PORT_LATCH 6'h00
`define DCC_MASK_VREF_CTRL 8'hef
`define DCC_MASK_PERIPH 8'hc0

// ----------------------------------------------------------------------
// comparator mode codes
// ----------------------------------------------------------------------
`define DCC_MODE_RESET 3'h0
`define DCC_MODE_INT_REF 3'h2
`define DCC_MODE_PIN_OUT 3'h6
`define DCC_MODE_OFF 3'h7

`endif

// ==== core/dcc_pkg.sv ====
/*
  Types shared by the dual comparator control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dcc_pkg;

  // pair of comparator decisions, second comparator in the upper bit
  typedef struct packed {
    logic second;
    logic first;
  } dcc_cmp_pair_t;

  // APB request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } dcc_apb_req_t;

endpackage

// ==== core/dcc_top.sv ====
/*
  Dual comparator control: APB register file, mode decode, pin routing,
  change-detect flag, interrupt request and sleep wake-up.
  Assumes the analog front end supplies raw comparator decisions that
  are asynchronous, and that port pins are asynchronous too.
*/
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

`include "dcc_consts.svh"

// Behaviour
// - output high when plus input exceeds minus
// - mode 010 puts internal reference on plus
// - outputs readable in control bits seven, six
// - mode 110 drives pins three, four raw
// - direction bits still enable pins three, four
// - analog pins read zero from port data
// - either output change sets comparator flag
// - flag at bit six, cleared by software only
// - request needs flag enable, peripheral, global enables
// - control access captures outputs, ends mismatch
// - persisting mismatch keeps setting flag each cycle
// - comparators run in sleep, change wakes device
// - wake-up leaves control register unchanged
// - mode 111 powers both comparators off
// - reset clears control, mode 000, powered down
// - control register holds outputs, switch, mode
module dcc_top (
  input wire logic sys_clk_in, // 200 MHz system clock
  input wire logic nrst_in, // synchronous reset, active low
  input wire logic psel_in, // APB select
  input wire logic penable_in, // APB enable
  input wire logic pwrite_in, // APB direction, high for write
  input wire logic [11:0] paddr_in, // APB byte address
  input wire logic [31:0] pwdata_in, // APB write data
  output logic [31:0] prdata_out, // APB read data
  output logic pready_out, // APB ready
  output logic pslverr_out, // APB error, unmapped address
  input wire dcc_pkg::dcc_cmp_pair_t cmp_raw_in, // raw analog decisions
  input wire logic sleep_in, // device is in sleep
  input wire logic [5:0] port_pin_in, // port pin levels
  output logic [5:0] port_pin_out, // port pin drive levels
  output logic [5:0] port_pin_oe_out, // port pin drive enables
  output logic irq_out, // interrupt request to cpu
  output logic wake_out, // wake request while asleep
  output logic cmp_power_out, // comparators powered
  output logic int_ref_sel_out, // internal reference to plus inputs
  output logic [2:0] cmp_mode_out, // mode to analog muxes
  output logic input_switch_out, // input switch to analog muxes
  output logic [7:0] vref_ctrl_out // reference ladder control
);
  import dcc_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  dcc_apb_req_t req;
  logic [7:0] idx;
  logic mapped;
  logic setup_phase;
  logic access_done;
  logic wr_done;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;

  logic [7:0] int_ctrl_ff;
  logic [7:0] periph_en_ff;
  logic [7:0] vref_ctrl_ff;
  logic [5:0] port_dir_ff;
  logic [5:0] port_latch_ff;
  logic input_switch_ff;
  logic [2:0] cmp_mode_ff;
  logic cmp_flag_ff;
  logic par_flag_ff;

  logic [5:0] pin_meta_ff;
  logic [5:0] pin_sync_ff;
  logic [5:0] analog_mask;
  logic [5:0] pin_read;

  logic cmp_powered;
  logic cmp_capture;
  dcc_cmp_pair_t cmp_status;
  logic cmp_mismatch;
  logic [7:0] cmp_ctrl_rd;

  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic wake_ff;
  logic power_ff;
  logic int_ref_ff;
  logic [5:0] pin_oe_ff;
  logic [5:0] pin_drv_ff;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  assign req = '{sel: psel_in, enable: penable_in, write: pwrite_in,
                 addr: paddr_in, wdata: pwdata_in};
  assign idx = req.addr[9:2];
  assign setup_phase = req.sel && !req.enable;
  assign access_done = req.sel && req.enable && pready_ff;
  assign wr_done = access_done && req.write && !pslverr_ff;
  assign wbyte = req.wdata[7:0];
  assign mapped = (req.addr[11:10] == 2'b00) && (req.addr[1:0] == 2'b00) &&
                  (idx inside {`DCC_IDX_PORT_DATA, `DCC_IDX_INT_CTRL,
                               `DCC_IDX_PERIPH_FLAGS, `DCC_IDX_CMP_CTRL,
                               `DCC_IDX_PORT_DIR, `DCC_IDX_PERIPH_EN,
                               `DCC_IDX_VREF_CTRL});

  // ----------------------------------------------------------------------
  // comparator power and change detection
  // ----------------------------------------------------------------------
  // mode 111 powers comparators off
  // reset mode keeps them powered down
  assign cmp_powered = (cmp_mode_ff != `DCC_MODE_OFF) &&
                       (cmp_mode_ff != `DCC_MODE_RESET);

  // any read or write of control register
  assign cmp_capture = access_done && !pslverr_ff &&
                       (idx == `DCC_IDX_CMP_CTRL);

  dcc_change_det u_change_det (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .raw_in(cmp_raw_in),
    .powered_in(cmp_powered),
    .capture_in(cmp_capture),
    .status_out(cmp_status),
    .mismatch_out(cmp_mismatch)
  );

  // status bits on top of control register
  always_comb begin
    cmp_ctrl_rd = 8'h00;
    cmp_ctrl_rd[`DCC_BIT_SECOND_OUT] = cmp_status.second;
    cmp_ctrl_rd[`DCC_BIT_FIRST_OUT] = cmp_status.first;
    cmp_ctrl_rd[`DCC_BIT_INPUT_SWITCH] = input_switch_ff;
    cmp_ctrl_rd[`DCC_MODE_MSB:`DCC_MODE_LSB] = cmp_mode_ff;
  end

  // ----------------------------------------------------------------------
  // port pins
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pin_meta_ff <= 6'h00;
      pin_sync_ff <= 6'h00;
    end else begin
      pin_meta_ff <= port_pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // pins taken as analog inputs in each mode
  always_comb begin
    case (cmp_mode_ff)
      3'h0, 3'h1, 3'h2: analog_mask = 6'h0f;
      3'h3, 3'h6: analog_mask = 6'h07;
      3'h4: analog_mask = 6'h0b;
      3'h5: analog_mask = 6'h06;
      default: analog_mask = 6'h00;
    endcase
  end

  assign pin_read = pin_sync_ff & ~analog_mask;

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  always_comb begin
    case (idx)
      `DCC_IDX_PORT_DATA: rd_byte = {2'b00, pin_read};
      `DCC_IDX_INT_CTRL: rd_byte = int_ctrl_ff;
      `DCC_IDX_PERIPH_FLAGS: rd_byte = {par_flag_ff, cmp_flag_ff, 6'h00};
      `DCC_IDX_CMP_CTRL: rd_byte = cmp_ctrl_rd;
      `DCC_IDX_PORT_DIR: rd_byte = {2'b00, port_dir_ff};
      `DCC_IDX_PERIPH_EN: rd_byte = periph_en_ff & `DCC_MASK_PERIPH;
      `DCC_IDX_VREF_CTRL: rd_byte = vref_ctrl_ff & `DCC_MASK_VREF_CTRL;
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // APB answer, one wait-free access phase
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (setup_phase) begin
      pready_ff <= 1'b1;
      pslverr_ff <= !mapped;
      prdata_ff <= (mapped && !req.write) ? {24'h00_0000, rd_byte} :
                   32'h0000_0000;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  // reset clears control register to mode 000
  // sleep and wake never touch it
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      input_switch_ff <= 1'(`DCC_RST_CMP_CTRL >> `DCC_BIT_INPUT_SWITCH);
      cmp_mode_ff <= 3'(`DCC_RST_CMP_CTRL);
    end else if (wr_done && (idx == `DCC_IDX_CMP_CTRL)) begin
      input_switch_ff <= wbyte[`DCC_BIT_INPUT_SWITCH];
      cmp_mode_ff <= wbyte[`DCC_MODE_MSB:`DCC_MODE_LSB];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      int_ctrl_ff <= `DCC_RST_INT_CTRL;
    end else if (wr_done && (idx == `DCC_IDX_INT_CTRL)) begin
      int_ctrl_ff <= wbyte;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      periph_en_ff <= `DCC_RST_PERIPH_EN;
    end else if (wr_done && (idx == `DCC_IDX_PERIPH_EN)) begin
      periph_en_ff <= wbyte & `DCC_MASK_PERIPH;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      vref_ctrl_ff <= `DCC_RST_VREF_CTRL;
    end else if (wr_done && (idx == `DCC_IDX_VREF_CTRL)) begin
      vref_ctrl_ff <= wbyte & `DCC_MASK_VREF_CTRL;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      port_dir_ff <= `DCC_RST_PORT_DIR;
    end else if (wr_done && (idx == `DCC_IDX_PORT_DIR)) begin
      port_dir_ff <= wbyte[5:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      port_latch_ff <= `DCC_RST_PORT_LATCH;
    end else if (wr_done && (idx == `DCC_IDX_PORT_DATA)) begin
      port_latch_ff <= wbyte[5:0];
    end
  end

  // ----------------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------------
  // change sets flag
  // set every cycle while mismatch lasts, set wins
  // only a software write clears it
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      cmp_flag_ff <= 1'(`DCC_RST_PERIPH_FLAGS >> `DCC_BIT_CMP_IRQ);
    end else if (cmp_mismatch) begin
      cmp_flag_ff <= 1'b1;
    end else if (wr_done && (idx == `DCC_IDX_PERIPH_FLAGS)) begin
      cmp_flag_ff <= wbyte[`DCC_BIT_CMP_IRQ];
    end
  end

  // parallel port flag is plain storage here
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      par_flag_ff <= 1'(`DCC_RST_PERIPH_FLAGS >> `DCC_BIT_PAR_PORT);
    end else if (wr_done && (idx == `DCC_IDX_PERIPH_FLAGS)) begin
      par_flag_ff <= wbyte[`DCC_BIT_PAR_PORT];
    end
  end

  // ----------------------------------------------------------------------
  // interrupt and wake-up
  // ----------------------------------------------------------------------
  // all three enables needed
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= cmp_flag_ff && periph_en_ff[`DCC_BIT_CMP_IRQ] &&
                int_ctrl_ff[`DCC_BIT_PERIPH_IRQ_EN] &&
                int_ctrl_ff[`DCC_BIT_GLOBAL_IRQ_EN];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= sleep_in && cmp_flag_ff &&
                 periph_en_ff[`DCC_BIT_CMP_IRQ] &&
                 int_ctrl_ff[`DCC_BIT_PERIPH_IRQ_EN];
    end
  end

  // ----------------------------------------------------------------------
  // analog controls and pin drive
  // ----------------------------------------------------------------------
  // powered down during reset
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      power_ff <= 1'b0;
      int_ref_ff <= 1'b0;
    end else begin
      power_ff <= cmp_powered;
      int_ref_ff <= (cmp_mode_ff == `DCC_MODE_INT_REF);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pin_oe_ff <= ~`DCC_RST_PORT_DIR;
      pin_drv_ff <= `DCC_RST_PORT_LATCH;
    end else begin
      pin_oe_ff <= ~port_dir_ff;
      pin_drv_ff <= port_latch_ff;
    end
  end

  // raw comparator decisions bypass all flops
  // raw high means plus input above minus
  always_comb begin
    port_pin_out = pin_drv_ff;
    if (cmp_mode_ff == `DCC_MODE_PIN_OUT) begin
      port_pin_out[`DCC_BIT_PIN_THREE] = cmp_raw_in.first;
      port_pin_out[`DCC_BIT_PIN_FOUR] = cmp_raw_in.second;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign irq_out = irq_ff;
  assign wake_out = wake_ff;
  assign cmp_power_out = power_ff;
  assign int_ref_sel_out = int_ref_ff;
  assign cmp_mode_out = cmp_mode_ff;
  assign input_switch_out = input_switch_ff;
  assign vref_ctrl_out = vref_ctrl_ff;
  assign port_pin_oe_out = pin_oe_ff;

endmodule

`default_nettype wire

// ==== tb/dcc_analog_model.sv ====
/*
  Analog side of the comparators: pin levels, reference ladder and
  the two raw decisions. Assumes millivolt levels from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module dcc_analog_model #(
  parameter int SUPPLY_MV = 5000
) (
  input wire logic int_ref_sel_in, // reference onto plus inputs
  input wire logic power_in, // comparators powered
  input wire logic [7:0] vref_ctrl_in, // ladder control
  input wire logic [15:0] p1_mv_in, // first plus pin
  input wire logic [15:0] n1_mv_in, // first minus pin
  input wire logic [15:0] p2_mv_in, // second plus pin
  input wire logic [15:0] n2_mv_in, // second minus pin
  output var dcc_pkg::dcc_cmp_pair_t cmp_raw_out // raw decisions
);
  import dcc_pkg::*;
  int ref_mv;
  int plus1;
  int plus2;
  // --------------------------------------------------------------------
  // ladder and routing
  // --------------------------------------------------------------------
  always_comb begin
    if (!vref_ctrl_in[7]) begin
      ref_mv = 0;
    end else if (vref_ctrl_in[5]) begin
      ref_mv = int'(vref_ctrl_in[3:0]) * SUPPLY_MV / 24;
    end else begin
      ref_mv = SUPPLY_MV / 4 + int'(vref_ctrl_in[3:0]) * SUPPLY_MV / 32;
    end
  end
  assign plus1 = int_ref_sel_in ? ref_mv : int'(p1_mv_in);
  assign plus2 = int_ref_sel_in ? ref_mv : int'(p2_mv_in);
  assign cmp_raw_out = {power_in && plus2 > int'(n2_mv_in),
    power_in && plus1 > int'(n1_mv_in)};
endmodule
`default_nettype wire

// ==== tb/dcc_props.sv ====
/*
  Port checker of dcc_top, bound to every instance below.
  Assumes dcc_consts.svh on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dcc_consts.svh"
module dcc_props (
  input wire logic sys_clk_in, // clock
  input wire logic nrst_in, // reset, active low
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb direction
  input wire logic [11:0] paddr_in, // apb address
  input wire logic [31:0] prdata_out, // apb read data
  input wire logic pready_out, // apb ready
  input wire dcc_pkg::dcc_cmp_pair_t cmp_raw_in, // raw decisions
  input wire logic sleep_in, // asleep
  input wire logic [5:0] port_pin_out, // pin levels
  input wire logic [5:0] port_pin_oe_out, // pin enables
  input wire logic irq_out, // interrupt
  input wire logic wake_out, // wake
  input wire logic cmp_power_out, // powered
  input wire logic int_ref_sel_out, // internal reference
  input wire logic [2:0] cmp_mode_out, // mode
  input wire logic input_switch_out // input switch
);
  import dcc_pkg::*;
  logic rd_ctrl_ff;
  logic rd_port_ff;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  // --------------------------------------------------------------------
  // setup cycles of reads
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    rd_ctrl_ff <= psel_in && !penable_in && !pwrite_in && paddr_in == 12'h07c;
    rd_port_ff <= psel_in && !penable_in && !pwrite_in && paddr_in == 12'h014;
  end
  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  chk_reset_state: assert property (disable iff (1'b0)
    !nrst_in |=> cmp_mode_out == `DCC_MODE_RESET && !cmp_power_out &&
      !irq_out && !wake_out && port_pin_oe_out == 6'h00 && !input_switch_out)
    else $error("state after reset wrong");
  chk_power_mode: assert property (
    $stable(cmp_mode_out) |-> cmp_power_out == (cmp_mode_out !=
      `DCC_MODE_RESET && cmp_mode_out != `DCC_MODE_OFF))
    else $error("power does not follow mode");
  chk_ref_route: assert property (
    $stable(cmp_mode_out) |->
      int_ref_sel_out == (cmp_mode_out == `DCC_MODE_INT_REF))
    else $error("reference select does not follow mode");
  chk_pin_route: assert property (
    cmp_mode_out == `DCC_MODE_PIN_OUT |->
      port_pin_out[4:3] == {cmp_raw_in.second, cmp_raw_in.first})
    else $error("pins three four not raw outputs");
  chk_ctrl_hold: assert property (
    !(psel_in && penable_in && pwrite_in) |=>
      $stable({input_switch_out, cmp_mode_out}))
    else $error("control changed without write");
  chk_wake_sleep: assert property (
    irq_out && $past(sleep_in) |-> wake_out)
    else $error("no wake for request in sleep");
  chk_ctrl_read: assert property (
    pready_out && rd_ctrl_ff |-> prdata_out[31:0] ==
      {24'h00_0000, prdata_out[7:6], 2'b00, input_switch_out, cmp_mode_out})
    else $error("control read data wrong");
  chk_port_analog: assert property (
    pready_out && rd_port_ff && cmp_mode_out == `DCC_MODE_RESET |->
      prdata_out[7:6] == 2'b00 && prdata_out[3:0] == 4'h0)
    else $error("analog pins not read as zero");
  cov_pin_out: cover property (cmp_mode_out == `DCC_MODE_PIN_OUT &&
    port_pin_oe_out[4:3] == 2'b11);
  cov_irq: cover property (irq_out);
  cov_wake: cover property (wake_out);
endmodule
bind dcc_top dcc_props i_props (.sys_clk_in, .nrst_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .prdata_out, .pready_out,
  .cmp_raw_in, .sleep_in, .port_pin_out, .port_pin_oe_out, .irq_out,
  .wake_out, .cmp_power_out, .int_ref_sel_out, .cmp_mode_out,
  .input_switch_out);
`default_nettype wire

// ==== tb/dcc_top_bench.sv ====
/*
  Self-checking bench of dcc_top with the analog model, one task per
  scenario. Assumes package, design, checker and model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dcc_consts.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
  n_mismatch++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module dcc_top_bench;
  import dcc_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, irq, wake, power, iref, sw, err;
  logic sleep = 1'b0;
  logic [5:0] pin_in = 6'h00;
  logic [5:0] pin_out, pin_oe;
  logic [2:0] mode;
  logic [7:0] vref, rd;
  logic [15:0] p1 = 16'h0000, n1 = 16'h0000, p2 = 16'h0000, n2 = 16'h0000;
  dcc_cmp_pair_t raw;
  int n_mismatch = 0;
  int checks_done = 0;
  always #2.5 clk = ~clk;
  dcc_top i_dut (
    .sys_clk_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .cmp_raw_in(raw), .sleep_in(sleep), .port_pin_in(pin_in),
    .port_pin_out(pin_out), .port_pin_oe_out(pin_oe), .irq_out(irq),
    .wake_out(wake), .cmp_power_out(power), .int_ref_sel_out(iref),
    .cmp_mode_out(mode), .input_switch_out(sw), .vref_ctrl_out(vref)
  );
  dcc_analog_model i_analog (
    .int_ref_sel_in(iref), .power_in(power), .vref_ctrl_in(vref),
    .p1_mv_in(p1), .n1_mv_in(n1), .p2_mv_in(p2), .n2_mv_in(n2),
    .cmp_raw_out(raw)
  );
  // --------------------------------------------------------------------
  // bus and helper tasks
  // --------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] idx,
      input logic [7:0] wd, output logic [7:0] rdv);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_mismatch++;
      results();
    end
    rdv = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, rd);
  endtask
  task chkrd(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00, rd);
    `CHK({err, rd}, {1'b0, e})
  endtask
  task settle;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task t_reset;
    chkrd(`DCC_IDX_CMP_CTRL, 8'h00);
    chkrd(`DCC_IDX_PORT_DIR, 8'h3f);
    chkrd(`DCC_IDX_PERIPH_FLAGS, 8'h00);
    chkrd(`DCC_IDX_PERIPH_EN, 8'h00);
    chkrd(`DCC_IDX_INT_CTRL, 8'h00);
    apb(1'b0, 8'h40, 8'h00, rd);
    `CHK(err, 1'b1)
    $display("test reset done");
  endtask
  task t_ctrl;
    wr(`DCC_IDX_CMP_CTRL, 8'hcf);
    p1 <= 16'h0bb8;
    n1 <= 16'h03e8;
    p2 <= 16'h03e8;
    n2 <= 16'h0bb8;
    settle();
    `CHK({sw, power}, 2'b10)
    chkrd(`DCC_IDX_CMP_CTRL, 8'h0f);
    wr(`DCC_IDX_CMP_CTRL, 8'h03);
    settle();
    chkrd(`DCC_IDX_CMP_CTRL, 8'h43);
    p2 <= 16'h0fa0;
    settle();
    chkrd(`DCC_IDX_CMP_CTRL, 8'hc3);
    $display("test control done");
  endtask
  task t_intref;
    wr(`DCC_IDX_VREF_CTRL, 8'hb6);
    chkrd(`DCC_IDX_VREF_CTRL, 8'ha6);
    wr(`DCC_IDX_CMP_CTRL, 8'h02);
    settle();
    `CHK(iref, 1'b1)
    `CHK(vref, 8'ha6)
    chkrd(`DCC_IDX_CMP_CTRL, 8'h42);
    $display("test reference done");
  endtask
  task t_pinout;
    wr(`DCC_IDX_PORT_DIR, 8'h27);
    wr(`DCC_IDX_CMP_CTRL, 8'h06);
    wr(`DCC_IDX_PORT_DATA, 8'h25);
    settle();
    `CHK(pin_oe, 6'h18)
    `CHK(pin_out, 6'h3d)
    @(posedge clk);
    p2 <= 16'h03e8;
    @(negedge clk);
    `CHK(pin_out[4:3], 2'b01)
    wr(`DCC_IDX_PORT_DIR, 8'h2f);
    settle();
    `CHK(pin_oe, 6'h10)
    wr(`DCC_IDX_PORT_DIR, 8'h3f);
    $display("test pin output done");
  endtask
  task t_analog;
    pin_in <= 6'h3f;
    wr(`DCC_IDX_CMP_CTRL, 8'h00);
    settle();
    chkrd(`DCC_IDX_PORT_DATA, 8'h30);
    wr(`DCC_IDX_CMP_CTRL, 8'h01);
    chkrd(`DCC_IDX_PORT_DATA, 8'h30);
    wr(`DCC_IDX_CMP_CTRL, 8'h04);
    chkrd(`DCC_IDX_PORT_DATA, 8'h34);
    wr(`DCC_IDX_CMP_CTRL, 8'h05);
    chkrd(`DCC_IDX_PORT_DATA, 8'h39);
    wr(`DCC_IDX_CMP_CTRL, 8'h07);
    settle();
    chkrd(`DCC_IDX_PORT_DATA, 8'h3f);
    $display("test analog read done");
  endtask
  task t_flag;
    p1 <= 16'h0000;
    p2 <= 16'h0000;
    wr(`DCC_IDX_CMP_CTRL, 8'h03);
    settle();
    chkrd(`DCC_IDX_CMP_CTRL, 8'h03);
    wr(`DCC_IDX_PERIPH_FLAGS, 8'h00);
    chkrd(`DCC_IDX_PERIPH_FLAGS, 8'h00);
    wr(`DCC_IDX_PERIPH_EN, 8'h40);
    wr(`DCC_IDX_INT_CTRL, 8'h40);
    p1 <= 16'h0bb8;
    settle();
    chkrd(`DCC_IDX_PERIPH_FLAGS, 8'h40);
    `CHK(irq, 1'b0)
    wr(`DCC_IDX_INT_CTRL, 8'hc0);
    settle();
    `CHK(irq, 1'b1)
    wr(`DCC_IDX_PERIPH_FLAGS, 8'h00);
    chkrd(`DCC_IDX_PERIPH_FLAGS, 8'h40);
    chkrd(`DCC_IDX_CMP_CTRL, 8'h43);
    chkrd(`DCC_IDX_PERIPH_FLAGS, 8'h40);
    wr(`DCC_IDX_PERIPH_FLAGS, 8'h00);
    settle();
    `CHK(irq, 1'b0)
    @(posedge clk);
    p2 <= 16'h0fa0;
    settle();
    chkrd(`DCC_IDX_PERIPH_FLAGS, 8'h40);
    chkrd(`DCC_IDX_CMP_CTRL, 8'hc3);
    wr(`DCC_IDX_PERIPH_FLAGS, 8'h00);
    $display("test flag done");
  endtask
  task t_sleep;
    sleep <= 1'b1;
    p1 <= 16'h0000;
    settle();
    `CHK({wake, irq}, 2'b11)
    @(posedge clk);
    sleep <= 1'b0;
    settle();
    `CHK(wake, 1'b0)
    chkrd(`DCC_IDX_CMP_CTRL, 8'h83);
    wr(`DCC_IDX_CMP_CTRL, 8'h07);
    settle();
    chkrd(`DCC_IDX_CMP_CTRL, 8'h07);
    wr(`DCC_IDX_PERIPH_FLAGS, 8'h00);
    p2 <= 16'h0000;
    settle();
    chkrd(`DCC_IDX_PERIPH_FLAGS, 8'h00);
    wr(`DCC_IDX_CMP_CTRL, 8'h0b);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    `CHK({sw, mode, power, irq}, 6'h00)
    chkrd(`DCC_IDX_CMP_CTRL, 8'h00);
    $display("test sleep and reset done");
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_ctrl();
    t_intref();
    t_pinout();
    t_analog();
    t_flag();
    t_sleep();
    results();
  end
endmodule
`default_nettype wire
